/* File: verilog/phmp_pkg.sv */
// Constants for the parallel host message port
package phmp_pkg;
  // Register selects on the two address lines
  localparam logic [1:0] ADDR_MESSAGE = 2'h0;
  localparam logic [1:0] ADDR_CONTROL = 2'h1;
  localparam logic [1:0] ADDR_AUDIO_FIRST = 2'h2;
  localparam logic [1:0] ADDR_AUDIO_SECOND = 2'h3;
  // Control register field positions
  localparam int BIT_OUT_READY = 1;
  localparam int BIT_IN_BUSY = 2;
  localparam int BIT_BYTE_SEL_LO = 3;
  localparam int BIT_BYTE_SEL_HI = 4;
  localparam logic [1:0] BYTE_SEL_RESET = 2'h3;
  // Message lengths in bytes
  localparam logic [2:0] BOOT_CMD_LEN = 3'h3;
  localparam logic [2:0] BOOT_RESP_LEN = 3'h1;
  localparam logic [2:0] RUN_RESP_LEN = 3'h6;
  // Message word of the post-processor port
  localparam int WORD_BYTES = 4;
  localparam logic [1:0] LAST_BYTE_POS = 2'h3;
  // Outbound response buffer
  localparam int RESP_FIFO_WIDTH = 8;
  localparam int RESP_FIFO_DEPTH = 8;
  // Host settle time after a full response, in microseconds
  localparam int HOST_RECHECK_US = 100;
  localparam int CLK_MHZ = 20;
  localparam int HOST_RECHECK_CYCLES = HOST_RECHECK_US * CLK_MHZ;
endpackage

/* File: verilog/phmp_fifo.sv */
// Synchronous FIFO with valid and ready on both sides
module phmp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule

/* File: verilog/phmp_port.sv */
// Parallel host message port: decoder core port and post-processor core port
//
// Overview of operation
// - Decoder holds busy until byte consumed
// - Boot: three bytes in, one reply
// - Run-time replies are six bytes
// - Output ready only with valid byte
// - Byte path moves whole 32-bit word
// - Message register used as whole words
// - Busy sets after four bytes, clears on take
// - Ready sets on load; irq is inverse
// - Busy at bit 2, mirrored on pin
// - Word bytes move top to bottom
// - Audio registers are write-only
// - Address 00/01/10/11 select four registers
module phmp_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoder core port host pins
  input wire logic dec_cs_n,
  input wire logic dec_wr_n,
  input wire logic dec_rd_n,
  input wire logic [1:0] decoder_reg_select,
  input wire logic [7:0] dec_data_in,
  output logic [7:0] dec_data_out,
  output logic dec_data_oe,
  output logic decoder_irq_n,
  // Decoder processor side
  input wire logic dec_boot,
  output logic dec_cmd_valid,
  output logic [7:0] dec_cmd_data,
  input wire logic dec_cmd_take,
  output logic dec_handshake_done,
  input wire logic dec_resp_valid,
  input wire logic [7:0] dec_resp_data,
  output logic dec_resp_ready,
  output logic dec_msg_read,
  output logic pcm_input_valid,
  output logic [7:0] pcm_input_reg,
  output logic compressed_input_valid,
  output logic [7:0] compressed_input_reg,
  // Post-processor core port host pins
  input wire logic pp_cs_n,
  input wire logic pp_wr_n,
  input wire logic pp_rd_n,
  input wire logic [1:0] pp_addr,
  input wire logic [7:0] pp_data_in,
  output logic [7:0] pp_data_out,
  output logic pp_data_oe,
  output logic pp_busy_pin,
  output logic postproc_irq_n,
  // Post-processor side
  output logic pp_in_valid,
  output logic [31:0] pp_in_word,
  input wire logic pp_in_take,
  input wire logic pp_out_load,
  input wire logic [31:0] pp_out_word,
  output logic audio_input_valid,
  output logic audio_input_sel,
  output logic [7:0] audio_input_data
);
  // Synchroniser of one host pin group: {cs_n, wr_n, rd_n, addr, data}
  localparam int PW = 13;
  logic [PW-1:0] meta [2];
  logic [PW-1:0] sync [2];
  logic [PW-1:0] prev [2];
  wire [PW-1:0] raw [2];
  assign raw[0] = {dec_cs_n, dec_wr_n, dec_rd_n, decoder_reg_select, dec_data_in};
  assign raw[1] = {pp_cs_n, pp_wr_n, pp_rd_n, pp_addr, pp_data_in};

  wire wr_end [2];
  wire rd_end [2];
  wire rd_act [2];
  wire cs_end [2];
  wire [1:0] h_addr [2];
  wire [7:0] h_data [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta[g] <= {3'h7, 10'h000};
          sync[g] <= {3'h7, 10'h000};
          prev[g] <= {3'h7, 10'h000};
        end else begin
          meta[g] <= raw[g];
          sync[g] <= meta[g];
          prev[g] <= sync[g];
        end
      end
      // Strobe ends taken from the synchronised pins, data from before the edge
      assign wr_end[g] = ~prev[g][11] & sync[g][11] & ~prev[g][12];
      assign rd_end[g] = ~prev[g][10] & sync[g][10] & ~prev[g][12];
      assign rd_act[g] = ~sync[g][10] & ~sync[g][12];
      assign cs_end[g] = ~prev[g][12] & sync[g][12];
      assign h_addr[g] = prev[g][9:8];
      assign h_data[g] = prev[g][7:0];
    end
  endgenerate

  // Register select decode
  function automatic logic hit(input logic [1:0] a, input logic [1:0] code);
    hit = (a == code);
  endfunction

  // Decoder core port ------------------------------------------------------
  logic dec_in_busy;
  logic dec_out_ready;
  logic [7:0] dec_out_byte;
  logic [2:0] dec_boot_cnt;
  logic [2:0] dec_resp_cnt;
  wire fifo_valid;
  wire [7:0] fifo_data;
  // refill only an empty message register
  wire fifo_pop = fifo_valid & ~dec_out_ready;
  wire dec_wr_msg = wr_end[0] & hit(h_addr[0], phmp_pkg::ADDR_MESSAGE);
  wire dec_wr_pcm = wr_end[0] & hit(h_addr[0], phmp_pkg::ADDR_AUDIO_FIRST);
  wire dec_wr_cmp = wr_end[0] & hit(h_addr[0], phmp_pkg::ADDR_AUDIO_SECOND);
  wire dec_rd_msg = rd_end[0] & hit(h_addr[0], phmp_pkg::ADDR_MESSAGE);
  wire dec_cmd_accept = dec_wr_msg & ~dec_in_busy;
  // only a held byte counts as read
  wire dec_byte_read = dec_rd_msg & dec_out_ready;
  wire [2:0] dec_resp_len = dec_boot ? phmp_pkg::BOOT_RESP_LEN : phmp_pkg::RUN_RESP_LEN;
  wire dec_resp_last = (dec_resp_cnt == dec_resp_len - 3'h1);
  wire dec_boot_last = (dec_boot_cnt == phmp_pkg::BOOT_CMD_LEN - 3'h1);
  wire [7:0] dec_ctrl_val = {5'h00, dec_in_busy, dec_out_ready, 1'b0};
  // only message and control read back
  wire [7:0] dec_rd_val = hit(h_addr[0], phmp_pkg::ADDR_CONTROL) ? dec_ctrl_val :
                          hit(h_addr[0], phmp_pkg::ADDR_MESSAGE) ? dec_out_byte : 8'h00;

  phmp_fifo #(
    .WIDTH(phmp_pkg::RESP_FIFO_WIDTH),
    .DEPTH(phmp_pkg::RESP_FIFO_DEPTH)
  ) u_resp_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(dec_resp_valid),
    .in_data(dec_resp_data),
    .in_ready(dec_resp_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(~dec_out_ready)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_in_busy <= 1'b0;
      dec_cmd_valid <= 1'b0;
      dec_cmd_data <= 8'h00;
      dec_out_ready <= 1'b0;
      dec_out_byte <= 8'h00;
    end else begin
      // busy until consumed; a new byte wins over the take
      if (dec_cmd_accept) begin
        dec_in_busy <= 1'b1;
        dec_cmd_valid <= 1'b1;
        dec_cmd_data <= h_data[0];
      end else if (dec_cmd_take) begin
        dec_in_busy <= 1'b0;
        dec_cmd_valid <= 1'b0;
      end
      // ready set on load, cleared by the host read
      if (fifo_pop) begin
        dec_out_ready <= 1'b1;
        dec_out_byte <= fifo_data;
      end else if (dec_byte_read) begin
        dec_out_ready <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_boot_cnt <= 3'h0;
      dec_handshake_done <= 1'b0;
      dec_resp_cnt <= 3'h0;
      dec_msg_read <= 1'b0;
    end else begin
      if (!dec_boot) begin
        dec_boot_cnt <= 3'h0;
      end else if (dec_cmd_accept) begin
        dec_boot_cnt <= dec_boot_last ? 3'h0 : dec_boot_cnt + 3'h1;
      end
      dec_handshake_done <= dec_boot & dec_cmd_accept & dec_boot_last;
      if (dec_byte_read) begin
        dec_resp_cnt <= dec_resp_last ? 3'h0 : dec_resp_cnt + 3'h1;
      end
      dec_msg_read <= dec_byte_read & dec_resp_last;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_data_out <= 8'h00;
      dec_data_oe <= 1'b0;
      decoder_irq_n <= 1'b1;
      pcm_input_valid <= 1'b0;
      pcm_input_reg <= 8'h00;
      compressed_input_valid <= 1'b0;
      compressed_input_reg <= 8'h00;
    end else begin
      dec_data_out <= dec_rd_val;
      dec_data_oe <= rd_act[0];
      // interrupt low while a byte waits
      decoder_irq_n <= ~dec_out_ready;
      pcm_input_valid <= dec_wr_pcm;
      compressed_input_valid <= dec_wr_cmp;
      if (dec_wr_pcm) begin
        pcm_input_reg <= h_data[0];
      end
      if (dec_wr_cmp) begin
        compressed_input_reg <= h_data[0];
      end
    end
  end

  // Post-processor core port -----------------------------------------------
  logic pp_busy;
  logic pp_ready;
  logic [1:0] pp_wpos;
  logic [1:0] pp_rpos;
  logic [23:0] pp_shift;
  logic [31:0] pp_out_hold;
  logic [1:0] byte_sel;
  wire pp_wr_msg = wr_end[1] & hit(h_addr[1], phmp_pkg::ADDR_MESSAGE);
  wire pp_wr_ctl = wr_end[1] & hit(h_addr[1], phmp_pkg::ADDR_CONTROL);
  wire pp_wr_a1 = wr_end[1] & hit(h_addr[1], phmp_pkg::ADDR_AUDIO_FIRST);
  wire pp_wr_a2 = wr_end[1] & hit(h_addr[1], phmp_pkg::ADDR_AUDIO_SECOND);
  wire pp_rd_msg = rd_end[1] & hit(h_addr[1], phmp_pkg::ADDR_MESSAGE);
  wire pp_word_done = pp_wr_msg & (pp_wpos == phmp_pkg::LAST_BYTE_POS);
  // only a whole word is handed on
  wire pp_word_take = pp_word_done & ~pp_busy;
  // last byte read empties the register
  wire pp_word_read = pp_rd_msg & (pp_rpos == phmp_pkg::LAST_BYTE_POS);
  // byte out by position, top first
  wire [7:0] pp_msg_byte = pp_out_hold[8*(3-pp_rpos) +: 8];
  // busy at bit 2; reserved zero
  wire [7:0] pp_ctrl_val = {3'h0, byte_sel, pp_busy, pp_ready, 1'b0};
  wire [7:0] pp_rd_val = hit(h_addr[1], phmp_pkg::ADDR_CONTROL) ? pp_ctrl_val :
                         hit(h_addr[1], phmp_pkg::ADDR_MESSAGE) ? pp_msg_byte : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pp_wpos <= 2'h0;
      pp_rpos <= 2'h0;
      pp_shift <= 24'h000000;
    end else begin
      // position restarts when chip select ends
      if (cs_end[1]) begin
        pp_wpos <= 2'h0;
        pp_rpos <= 2'h0;
      end else begin
        // one byte per strobe into the word
        if (pp_wr_msg) begin
          pp_wpos <= pp_wpos + 2'h1;
          pp_shift <= {pp_shift[15:0], h_data[1]};
        end
        if (pp_rd_msg) begin
          pp_rpos <= pp_rpos + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pp_busy <= 1'b0;
      pp_in_word <= 32'h00000000;
      pp_ready <= 1'b0;
      pp_out_hold <= 32'h00000000;
      byte_sel <= phmp_pkg::BYTE_SEL_RESET;
    end else begin
      // busy on full word, cleared on take; set wins
      if (pp_word_take) begin
        pp_busy <= 1'b1;
        pp_in_word <= {pp_shift, h_data[1]};
      end else if (pp_in_take) begin
        pp_busy <= 1'b0;
      end
      // ready on load, cleared by host read; set wins
      if (pp_out_load) begin
        pp_ready <= 1'b1;
        pp_out_hold <= pp_out_word;
      end else if (pp_word_read) begin
        pp_ready <= 1'b0;
      end
      // control write keeps only the select field
      if (pp_wr_ctl) begin
        byte_sel <= h_data[1][phmp_pkg::BIT_BYTE_SEL_HI:phmp_pkg::BIT_BYTE_SEL_LO];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pp_data_out <= 8'h00;
      pp_data_oe <= 1'b0;
      pp_busy_pin <= 1'b0;
      postproc_irq_n <= 1'b1;
      pp_in_valid <= 1'b0;
      audio_input_valid <= 1'b0;
      audio_input_sel <= 1'b0;
      audio_input_data <= 8'h00;
    end else begin
      pp_data_out <= pp_rd_val;
      pp_data_oe <= rd_act[1];
      pp_busy_pin <= pp_busy;
      postproc_irq_n <= ~pp_ready;
      pp_in_valid <= pp_busy;
      audio_input_valid <= pp_wr_a1 | pp_wr_a2;
      if (pp_wr_a1 | pp_wr_a2) begin
        audio_input_sel <= pp_wr_a2;
        audio_input_data <= h_data[1];
      end
    end
  end
endmodule

/* File: bench/phmp_port_asserts.sv */
// Checker for the parallel host message port, bound to its ports
module phmp_port_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoder core port
  input wire logic dec_cs_n,
  input wire logic dec_rd_n,
  input wire logic dec_data_oe,
  input wire logic dec_boot,
  input wire logic dec_handshake_done,
  input wire logic dec_msg_read,
  input wire logic dec_resp_valid,
  input wire logic dec_resp_ready,
  input wire logic pcm_input_valid,
  input wire logic compressed_input_valid,
  // Post-processor core port
  input wire logic pp_busy_pin,
  input wire logic pp_in_valid,
  input wire logic pp_in_take,
  input wire logic pp_out_load,
  input wire logic postproc_irq_n,
  input wire logic pp_cs_n,
  input wire logic pp_rd_n,
  input wire logic pp_data_oe,
  input wire logic audio_input_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic dec_rd_act;
  assign dec_rd_act = !dec_cs_n && !dec_rd_n;
  oe_idle_a: assert property (!dec_rd_act [*5] |-> !dec_data_oe)
    else $error("decoder data driven without a read");
  irq_fall_a: assert property ($fell(postproc_irq_n) |->
    $past(pp_out_load) || $past(pp_out_load, 2)) else $error("irq low without a load");
  take_clear_a: assert property (pp_in_take && pp_busy_pin |-> ##[1:3] !pp_busy_pin)
    else $error("busy pin stuck after take");
  busy_fall_a: assert property ($fell(pp_busy_pin) |->
    $past(pp_in_take) || $past(pp_in_take, 2)) else $error("busy fell without a take");
  in_valid_a: assert property ($rose(pp_busy_pin) |-> ##[0:1] pp_in_valid)
    else $error("word valid missing after busy");
  pcm_pulse_a: assert property (pcm_input_valid |=> !pcm_input_valid)
    else $error("pcm valid longer than one cycle");
  audio_excl_a: assert property (pcm_input_valid |-> !compressed_input_valid)
    else $error("two data registers written at once");
  msg_pulse_a: assert property (dec_msg_read |=> !dec_msg_read [*3])
    else $error("message done pulses too close");
  hs_boot_a: assert property (dec_handshake_done |-> $past(dec_boot))
    else $error("handshake outside boot");
  pp_oe_read_a: assert property ((!pp_cs_n && !pp_rd_n) [*4] |-> pp_data_oe)
    else $error("post-processor data not driven during a read");
  audio_pulse_a: assert property (audio_input_valid |=> !audio_input_valid)
    else $error("audio valid longer than one cycle");
  cover property ($fell(postproc_irq_n));
  cover property (dec_handshake_done);
  cover property (dec_resp_valid && !dec_resp_ready);
endmodule

bind phmp_port phmp_port_asserts u_chk (.clk, .rst, .dec_cs_n, .dec_rd_n, .dec_data_oe,
  .dec_boot, .dec_handshake_done, .dec_msg_read, .dec_resp_valid, .dec_resp_ready,
  .pcm_input_valid, .compressed_input_valid, .pp_busy_pin, .pp_in_valid, .pp_in_take,
  .pp_out_load, .postproc_irq_n, .pp_cs_n, .pp_rd_n, .pp_data_oe, .audio_input_valid);

/* File: bench/phmp_host_model.sv */
// Host processor model driving one byte-wide strobe port
module phmp_host_model (
  // Clock
  input wire logic clk,
  // Host pins
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [1:0] addr,
  output logic [7:0] dout,
  input wire logic [7:0] din
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    addr = 2'h0;
    dout = 8'h00;
  end
  // Bytes strobed in order, select held while keep is set
  task automatic put(input logic [1:0] a, input logic [7:0] d, input bit keep);
    addr = a;
    dout = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (4) @(negedge clk);
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
    dout = ~d;
    if (!keep) begin
      cs_n = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask
  task automatic get(input logic [1:0] a, output logic [7:0] v, input bit keep);
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (4) @(negedge clk);
    v = din;
    rd_n = 1'b1;
    repeat (4) @(negedge clk);
    if (!keep) begin
      cs_n = 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask
  // Poll a flag before each byte
  task automatic poll(input int b, input logic want, output bit ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      get(2'h1, v, 1'b0);
      ok = (v[b] === want);
    end
  endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the parallel host message port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] MSG = phmp_pkg::ADDR_MESSAGE;
  localparam logic [1:0] CTL = phmp_pkg::ADDR_CONTROL;
  logic clk, rst, dec_boot, dec_cmd_take, dec_resp_valid, pp_in_take, pp_out_load;
  logic dec_cs_n, dec_wr_n, dec_rd_n, pp_cs_n, pp_wr_n, pp_rd_n, dec_data_oe, pp_data_oe;
  logic [1:0] decoder_reg_select, pp_addr;
  logic [7:0] dec_data_in, dec_data_out, pp_data_in, pp_data_out, dec_resp_data, v;
  logic decoder_irq_n, dec_cmd_valid, dec_handshake_done, dec_resp_ready, dec_msg_read;
  logic pcm_input_valid, compressed_input_valid, pp_busy_pin, postproc_irq_n, pp_in_valid;
  logic audio_input_valid, audio_input_sel;
  logic [7:0] dec_cmd_data, pcm_input_reg, compressed_input_reg, audio_input_data;
  logic [31:0] pp_out_word, pp_in_word;
  int err_total, checks_done, n;
  int n_hs = 0;
  int n_msg = 0;
  bit ok;
  phmp_port dut (.clk, .rst, .dec_cs_n, .dec_wr_n, .dec_rd_n, .decoder_reg_select,
    .dec_data_in, .dec_data_out, .dec_data_oe, .decoder_irq_n, .dec_boot, .dec_cmd_valid,
    .dec_cmd_data, .dec_cmd_take, .dec_handshake_done, .dec_resp_valid, .dec_resp_data,
    .dec_resp_ready, .dec_msg_read, .pcm_input_valid, .pcm_input_reg, .compressed_input_valid,
    .compressed_input_reg, .pp_cs_n, .pp_wr_n, .pp_rd_n, .pp_addr, .pp_data_in, .pp_data_out,
    .pp_data_oe, .pp_busy_pin, .postproc_irq_n, .pp_in_valid, .pp_in_word, .pp_in_take,
    .pp_out_load, .pp_out_word, .audio_input_valid, .audio_input_sel, .audio_input_data);
  phmp_host_model hd (.clk, .cs_n(dec_cs_n), .wr_n(dec_wr_n), .rd_n(dec_rd_n),
    .addr(decoder_reg_select), .dout(dec_data_in), .din(dec_data_out));
  phmp_host_model hp (.clk, .cs_n(pp_cs_n), .wr_n(pp_wr_n), .rd_n(pp_rd_n),
    .addr(pp_addr), .dout(pp_data_in), .din(pp_data_out));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    n_hs <= n_hs + int'(dec_handshake_done === 1'b1);
    n_msg <= n_msg + int'(dec_msg_read === 1'b1);
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic push(input int want);
    n = 0;
    for (int c = 0; c < 24 && n < want; c++) begin
      @(negedge clk);
      dec_resp_valid = 1'b1;
      dec_resp_data = 8'h40 + 8'(n);
      if (dec_resp_ready === 1'b1) n++;
    end
    @(negedge clk);
    dec_resp_valid = 1'b0;
  endtask
  task automatic drain(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      hd.poll(1, 1'b1, ok);
      chk("ready seen", 1'b1, ok);
      hd.get(MSG, v, 1'b0);
      chk("reply byte", 8'h40 + i, v);
    end
  endtask
  task automatic pput(input logic [31:0] w, input int nb);
    for (int i = 0; i < nb; i++) hp.put(MSG, w[31-8*i -: 8], i < nb - 1);
  endtask
  task automatic t_reset;
    chk("pp irq_n", 1'b1, postproc_irq_n);
    hp.get(CTL, v, 1'b0);
    chk("pp control", 8'h18, v);
    hd.get(CTL, v, 1'b0);
    chk("dec control", 8'h00, v);
    $display("test reset done");
  endtask
  task automatic t_dec_write;
    hd.poll(2, 1'b0, ok);
    chk("busy low", 1'b1, ok);
    hd.put(MSG, 8'ha5, 1'b0);
    chk("command", 8'ha5, dec_cmd_data);
    chk("cmd valid", 1'b1, dec_cmd_valid);
    hd.get(CTL, v, 1'b0);
    chk("busy set", 8'h04, v);
    hd.put(MSG, 8'h5a, 1'b0);
    chk("command kept", 8'ha5, dec_cmd_data);
    pulse(dec_cmd_take);
    hd.get(CTL, v, 1'b0);
    chk("busy clear", 8'h00, v);
    chk("cmd valid clear", 1'b0, dec_cmd_valid);
    hd.put(2'h2, 8'h3c, 1'b0);
    chk("pcm", 8'h3c, pcm_input_reg);
    hd.put(2'h3, 8'hc3, 1'b0);
    chk("compressed", 8'hc3, compressed_input_reg);
    hd.get(2'h3, v, 1'b0);
    chk("data read", 8'h00, v);
    $display("test decoder write done");
  endtask
  task automatic t_boot;
    dec_boot = 1'b1;
    for (int i = 0; i < 3; i++) begin
      hd.put(MSG, 8'h80 + 8'(i), 1'b0);
      pulse(dec_cmd_take);
    end
    chk("handshake", 1, n_hs);
    push(1);
    drain(1);
    chk("boot reply", 1, n_msg);
    dec_boot = 1'b0;
    $display("test boot done");
  endtask
  task automatic t_run;
    push(20);
    chk("buffer refused", 1'b1, n >= 8 && n < 20);
    chk("dec irq_n", 1'b0, decoder_irq_n);
    drain(n);
    chk("run replies", 1 + n / 6, n_msg);
    repeat (phmp_pkg::HOST_RECHECK_CYCLES) @(negedge clk);
    hd.get(CTL, v, 1'b0);
    chk("ready clear", 8'h00, v);
    $display("test run replies done");
  endtask
  task automatic t_pp_word;
    pput(32'h1234_5678, 2);
    pput(32'h8123_45c6, 4);
    chk("word", 32'h8123_45c6, pp_in_word);
    chk("busy pin", 1'b1, pp_busy_pin);
    hp.get(CTL, v, 1'b0);
    chk("busy bit", 8'h1c, v);
    pput(32'hdead_beef, 4);
    chk("word kept", 32'h8123_45c6, pp_in_word);
    pulse(pp_in_take);
    chk("busy cleared", 1'b0, pp_busy_pin);
    hp.put(CTL, 8'h1e, 1'b0);
    hp.get(CTL, v, 1'b0);
    chk("control kept", 8'h18, v);
    hp.put(2'h3, 8'h22, 1'b0);
    chk("audio", 9'h122, {audio_input_sel, audio_input_data});
    hp.get(2'h2, v, 1'b0);
    chk("audio read", 8'h00, v);
    $display("test word write done");
  endtask
  task automatic t_pp_read;
    pp_out_word = 32'h9a0b_c1d2;
    pulse(pp_out_load);
    chk("irq low", 1'b0, postproc_irq_n);
    for (int i = 0; i < 4; i++) begin
      hp.get(MSG, v, i < 3);
      chk("word byte", pp_out_word[31-8*i -: 8], v);
    end
    chk("irq high", 1'b1, postproc_irq_n);
    $display("test word read done");
  endtask
  task automatic t_mid_reset;
    pulse(pp_out_load);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("flags in reset", 8'h00, {6'h00, dec_resp_ready, ~postproc_irq_n});
    repeat (4) @(negedge clk);
    chk("buffer ready", 1'b1, dec_resp_ready);
    hp.get(CTL, v, 1'b0);
    chk("pp control reset", 8'h18, v);
    $display("test mid reset done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {clk, rst, dec_boot, dec_cmd_take, dec_resp_valid, pp_in_take, pp_out_load} = 7'h20;
    {dec_resp_data, pp_out_word, err_total, checks_done} = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset;
    t_dec_write;
    t_boot;
    t_run;
    t_pp_word;
    t_pp_read;
    t_mid_reset;
    test_done;
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    $display("watchdog expired");
    test_done;
  end
endmodule
